// [include/kbm_cfg.svh]
// kbm constants: addresses, field positions, reset values and timing
`ifndef KBM_CFG_SVH
`define KBM_CFG_SVH
`define KBM_ADDR_DATA 8'h60
`define KBM_ADDR_CMD 8'h64
`define KBM_ADDR_FAST 8'h92
`define KBM_ADDR_BIT2 2
`define KBM_ST_OBF 0
`define KBM_ST_IBF 1
`define KBM_ST_FREE2 2
`define KBM_ST_CD 3
`define KBM_ST_FREE_HI 7:4
`define KBM_ST_RESET 8'h00
`define KBM_FAST_RESET 8'h24
`define KBM_FAST_ONES 8'h24
`define KBM_FAST_RST_BIT 0
`define KBM_FAST_A20_BIT 1
`define KBM_GLUE_EN_BIT 2
`define KBM_CLK_MHZ 100
`define KBM_FRST_DELAY_NS 500
`define KBM_FRST_PULSE_NS 1000
`define KBM_FRST_DELAY_CYC ((`KBM_FRST_DELAY_NS * `KBM_CLK_MHZ + 999) / 1000)
`define KBM_FRST_PULSE_CYC ((`KBM_FRST_PULSE_NS * `KBM_CLK_MHZ + 999) / 1000)
`define KBM_CNT_W 8
`define KBM_CORE_DIV_NUM 12
`define KBM_CORE_DIV_DEN 100
`define KBM_FIFO_DEPTH 8
`define KBM_FIFO_AW 3
`endif

// [include/kbm_pkg.sv]
// kbm package: types shared by the mailbox block
package kbm_pkg;
  typedef enum logic [1:0] {
    KBM_RUN,
    KBM_SOFT_HALT,
    KBM_OSC_STOP
  } kbm_power_type;
  typedef enum logic [1:0] {
    KBM_FR_IDLE,
    KBM_FR_DELAY,
    KBM_FR_PULSE,
    KBM_FR_DONE
  } kbm_fast_type;
  typedef enum logic [1:0] {
    KBM_CORE_NONE,
    KBM_CORE_INTR,
    KBM_CORE_NEXT,
    KBM_CORE_RESTART
  } kbm_wake_type;
endpackage

// [src/kbm_fifo.sv]
// kbm_fifo: small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`include "kbm_cfg.svh"
module kbm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `KBM_FIFO_DEPTH,
  parameter int AW = `KBM_FIFO_AW
) (
  // clocking
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] rdPtr_reg;
  logic [AW:0] count_reg;
  logic doPush;
  logic doPop;

  // honest flags straight from the occupancy count
  assign inReady = (count_reg != (AW+1)'(DEPTH));
  assign outValid = (count_reg != '0);
  assign outData = mem_reg[rdPtr_reg];
  assign doPush = clkEn && inValid && inReady;
  assign doPop = clkEn && outValid && outReady;

  // storage, no reset needed on data
  always_ff @(posedge clk) begin
    if (doPush) begin
      mem_reg[wrPtr_reg] <= inData;
    end
  end

  // pointers and count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (doPush) begin
        wrPtr_reg <= (wrPtr_reg == AW'(DEPTH - 1)) ? '0 : wrPtr_reg + AW'(1);
      end
      if (doPop) begin
        rdPtr_reg <= (rdPtr_reg == AW'(DEPTH - 1)) ? '0 : rdPtr_reg + AW'(1);
      end
      if (doPush && !doPop) begin
        count_reg <= count_reg + (AW+1)'(1);
      end else if (doPop && !doPush) begin
        count_reg <= count_reg - (AW+1)'(1);
      end
    end
  end
endmodule // kbm_fifo

// [src/kbm_mailbox.sv]
// kbm_mailbox: keyboard controller host mailbox, power-down and fast gate/reset
// Function
// - soft halt stops ALU clock, timer runs
// - idle opcode halts until reset or write
// - host-write wake: interrupt if enabled, else next
// - reset wake restarts core at address zero
// - stop opcode kills oscillator, same wake events
// - only input-full and timer overflow interrupts
// - core write loads byte, sets output-full, irq; here bytes queue and load when output-full is clear
// - core read returns host byte, clears input-full
// - status bits: obf0, ibf1, cd3, rest free
// - status host read-only, core writable, reset zero
// - host address bit2 selects command or data
// - host write sets input-full, requests core interrupt
// - host read of output clears output-full
// - core clock 12 MHz from reference
// - system reset drives lines low, status zero
// - fast register accessible only when glue bit2 set
// - fast register at 92h, resets 24h, fixed bits
// - bit1 write drives fast A20 gate level
// - bit0 one: 500 ns delay, 1 us low pulse
// - flag mode: kbd irq follows output-full if port4
// - flag mode: aux irq is inverted input-full if port5
// - data address clears cmd flag, command sets it
`timescale 1ns/1ps
`include "kbm_cfg.svh"
module kbm_mailbox
  import kbm_pkg::*;
(
  // clocking and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // host i/o port access
  input wire logic hostWr,
  input wire logic hostRd,
  input wire logic [7:0] hostAddr,
  input wire logic [7:0] hostWrData,
  output logic [7:0] hostRdData,
  output logic hostRdValid,
  // glue configuration register
  input wire logic [7:0] glueConfigReg,
  // core side data and status
  input wire logic coreDataWr,
  input wire logic [7:0] coreDataWrByte,
  input wire logic coreDataRd,
  output logic [7:0] coreDataRdByte,
  output logic coreDataReady,
  input wire logic coreStatusWr,
  input wire logic [7:0] coreStatusWrByte,
  output logic [7:0] coreStatusRdByte,
  // core control
  input wire logic coreIdleOp,
  input wire logic coreStopOp,
  input wire logic coreEnFlags,
  input wire logic coreIbfIntEn,
  input wire logic coreTimerOvf,
  input wire logic coreTimerIntEn,
  input wire logic corePortBit4,
  input wire logic corePortBit5,
  input wire logic [3:0] corePortLines,
  // core clocking and interrupt outputs
  output logic coreAluClkEn,
  output logic coreTimerClkEn,
  output logic oscDriverEn,
  output logic coreTick,
  output logic coreIntReq,
  output logic coreIntIsTimer,
  output logic [1:0] coreWake,
  // host-side pins
  output logic kbdHostIrq,
  output logic auxHostIrq,
  output logic kbdClockLine,
  output logic kbdDataLine,
  output logic auxClockLine,
  output logic auxDataLine,
  output logic fastA20Gate,
  output logic fastCpuReset_n
);
  logic [7:0] inByte_reg;
  logic [7:0] outByte_reg;
  logic [7:0] status_reg;
  logic [7:0] fastCtl_reg;
  kbm_power_type power_reg;
  kbm_fast_type fast_reg;
  logic [`KBM_CNT_W-1:0] fastCnt_reg;
  logic [6:0] divAcc_reg;
  logic fifoOutValid;
  logic [7:0] fifoOutData;
  logic fifoInReady;
  logic fastEn;
  logic hostWrMbx;
  logic hostWrFast;
  logic hostRdOut;
  logic hostRdFast;
  logic coreLoad;
  logic corePush;
  logic [`KBM_FIFO_AW:0] queueOcc_reg;
  logic [`KBM_FIFO_AW:0] queueOcc_next;

  // address decode, one helper for every host match
  function automatic logic addrIs(input logic [7:0] a, input logic [7:0] ref8);
    addrIs = (a == ref8);
  endfunction

  assign fastEn = glueConfigReg[`KBM_GLUE_EN_BIT];
  assign hostWrMbx = clkEn && hostWr && (addrIs(hostAddr, `KBM_ADDR_DATA) ||
    addrIs(hostAddr, `KBM_ADDR_CMD));
  assign hostWrFast = clkEn && hostWr && fastEn && addrIs(hostAddr, `KBM_ADDR_FAST);
  assign hostRdOut = clkEn && hostRd && addrIs(hostAddr, `KBM_ADDR_DATA);
  assign hostRdFast = clkEn && hostRd && fastEn && addrIs(hostAddr, `KBM_ADDR_FAST);
  // core output bytes queue up; the host buffer loads when it is empty
  assign coreLoad = clkEn && fifoOutValid && !status_reg[`KBM_ST_OBF];
  // a push is only taken while the queue has room
  assign corePush = clkEn && coreDataWr && fifoInReady;

  // core output queue, back-pressure reaches the core via coreDataReady
  kbm_fifo #(
    .WIDTH(8),
    .DEPTH(`KBM_FIFO_DEPTH),
    .AW(`KBM_FIFO_AW)
  ) outQueue (
    .clk(clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .inValid(coreDataWr),
    .inReady(fifoInReady),
    .inData(coreDataWrByte),
    .outValid(fifoOutValid),
    .outReady(!status_reg[`KBM_ST_OBF]),
    .outData(fifoOutData)
  );

  // occupancy mirror of the queue, so the ready output can come from a flip-flop
  always_comb begin
    queueOcc_next = queueOcc_reg;
    if (corePush && !coreLoad) begin
      queueOcc_next = queueOcc_reg + (`KBM_FIFO_AW+1)'(1);
    end else if (coreLoad && !corePush) begin
      queueOcc_next = queueOcc_reg - (`KBM_FIFO_AW+1)'(1);
    end
  end

  // registered ready; matches the queue's own full flag edge for edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      queueOcc_reg <= '0;
      coreDataReady <= 1'b1;
    end else if (clkEn) begin
      queueOcc_reg <= queueOcc_next;
      coreDataReady <= (queueOcc_next != (`KBM_FIFO_AW+1)'(`KBM_FIFO_DEPTH));
    end
  end

  // data bytes are not reset, matching the untouched data register
  always_ff @(posedge clk) begin
    if (hostWrMbx) begin
      inByte_reg <= hostWrData;
    end
    if (coreLoad) begin
      outByte_reg <= fifoOutData;
    end
  end

  // status byte: hardware set wins over core clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= `KBM_ST_RESET;
    end else if (clkEn) begin
      if (coreStatusWr) begin
        status_reg[`KBM_ST_FREE_HI] <= coreStatusWrByte[`KBM_ST_FREE_HI];
        status_reg[`KBM_ST_FREE2] <= coreStatusWrByte[`KBM_ST_FREE2];
        status_reg[`KBM_ST_CD] <= coreStatusWrByte[`KBM_ST_CD];
        status_reg[`KBM_ST_IBF] <= coreStatusWrByte[`KBM_ST_IBF];
        status_reg[`KBM_ST_OBF] <= coreStatusWrByte[`KBM_ST_OBF];
      end
      if (coreDataRd) begin
        status_reg[`KBM_ST_IBF] <= 1'b0;
      end
      if (hostRdOut) begin
        status_reg[`KBM_ST_OBF] <= 1'b0;
      end
      if (hostWrMbx) begin
        status_reg[`KBM_ST_IBF] <= 1'b1;
        status_reg[`KBM_ST_CD] <= hostAddr[`KBM_ADDR_BIT2];
      end
      if (coreLoad) begin
        status_reg[`KBM_ST_OBF] <= 1'b1;
      end
    end
  end

  // host read answers, registered one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hostRdData <= 8'h00;
      hostRdValid <= 1'b0;
    end else if (clkEn) begin
      hostRdValid <= hostRd;
      if (hostRdOut) begin
        hostRdData <= outByte_reg;
      end else if (hostRd && addrIs(hostAddr, `KBM_ADDR_CMD)) begin
        hostRdData <= status_reg;
      end else if (hostRdFast) begin
        hostRdData <= fastCtl_reg | `KBM_FAST_ONES;
      end else begin
        hostRdData <= 8'h00; // unmapped or disabled port reads zero
      end
    end
  end

  // core view of the mailbox
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      coreDataRdByte <= 8'h00;
      coreStatusRdByte <= 8'h00;
    end else if (clkEn) begin
      coreDataRdByte <= inByte_reg;
      coreStatusRdByte <= status_reg;
    end
  end

  // power state: halt or stop until reset or a host mailbox write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_reg <= KBM_RUN;
      coreWake <= KBM_CORE_RESTART;
    end else if (clkEn) begin
      coreWake <= KBM_CORE_NONE;
      case (power_reg)
        KBM_RUN: begin
          if (coreStopOp) begin
            power_reg <= KBM_OSC_STOP;
          end else if (coreIdleOp) begin
            power_reg <= KBM_SOFT_HALT;
          end
        end
        KBM_SOFT_HALT, KBM_OSC_STOP: begin
          if (hostWrMbx) begin
            power_reg <= KBM_RUN;
            coreWake <= coreIbfIntEn ? KBM_CORE_INTR : KBM_CORE_NEXT;
          end
        end
        default: begin
          power_reg <= KBM_RUN;
        end
      endcase
    end
  end

  // clock gating enables; the oscillator-stop wake relies on a long reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      coreAluClkEn <= 1'b1;
      coreTimerClkEn <= 1'b1;
      oscDriverEn <= 1'b1;
    end else if (clkEn) begin
      coreAluClkEn <= (power_reg == KBM_RUN);
      coreTimerClkEn <= (power_reg != KBM_OSC_STOP);
      oscDriverEn <= (power_reg != KBM_OSC_STOP);
    end
  end

  // fractional divider: 12 ticks per 100 clocks gives the 12 MHz core rate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divAcc_reg <= 7'h00;
      coreTick <= 1'b0;
    end else if (clkEn) begin
      if (divAcc_reg + 7'(`KBM_CORE_DIV_NUM) >= 7'(`KBM_CORE_DIV_DEN)) begin
        divAcc_reg <= divAcc_reg + 7'(`KBM_CORE_DIV_NUM) - 7'(`KBM_CORE_DIV_DEN);
        coreTick <= oscDriverEn;
      end else begin
        divAcc_reg <= divAcc_reg + 7'(`KBM_CORE_DIV_NUM);
        coreTick <= 1'b0;
      end
    end
  end

  // the two core interrupt sources, input-full first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      coreIntReq <= 1'b0;
      coreIntIsTimer <= 1'b0;
    end else if (clkEn) begin
      coreIntReq <= (status_reg[`KBM_ST_IBF] && coreIbfIntEn) ||
        (coreTimerOvf && coreTimerIntEn);
      coreIntIsTimer <= !(status_reg[`KBM_ST_IBF] && coreIbfIntEn);
    end
  end

  // host interrupts and serial port lines
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      kbdHostIrq <= 1'b0;
      auxHostIrq <= 1'b0;
      kbdClockLine <= 1'b0;
      kbdDataLine <= 1'b0;
      auxClockLine <= 1'b0;
      auxDataLine <= 1'b0;
    end else if (clkEn) begin
      if (coreEnFlags) begin
        kbdHostIrq <= corePortBit4 && status_reg[`KBM_ST_OBF];
        auxHostIrq <= corePortBit5 && !status_reg[`KBM_ST_IBF];
      end else begin
        kbdHostIrq <= corePortBit4;
        auxHostIrq <= corePortBit5;
      end
      kbdClockLine <= !corePortLines[0];
      kbdDataLine <= !corePortLines[1];
      auxClockLine <= !corePortLines[2];
      auxDataLine <= !corePortLines[3];
    end
  end

  // fast gate/reset register; bit0 stays set until written back to zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fastCtl_reg <= `KBM_FAST_RESET;
      fastA20Gate <= 1'b0;
    end else if (clkEn && hostWrFast) begin
      fastCtl_reg <= (hostWrData & 8'h03) | `KBM_FAST_ONES;
      fastA20Gate <= hostWrData[`KBM_FAST_A20_BIT];
    end
  end

  // fast cpu reset sequencer; the done state swallows repeat ones
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_reg <= KBM_FR_IDLE;
      fastCnt_reg <= '0;
      fastCpuReset_n <= 1'b1;
    end else if (clkEn) begin
      case (fast_reg)
        KBM_FR_IDLE: begin
          fastCpuReset_n <= 1'b1;
          if (fastCtl_reg[`KBM_FAST_RST_BIT]) begin
            fast_reg <= KBM_FR_DELAY;
            fastCnt_reg <= `KBM_CNT_W'(`KBM_FRST_DELAY_CYC - 1);
          end
        end
        KBM_FR_DELAY: begin
          if (fastCnt_reg == '0) begin
            fast_reg <= KBM_FR_PULSE;
            fastCnt_reg <= `KBM_CNT_W'(`KBM_FRST_PULSE_CYC - 1);
            fastCpuReset_n <= 1'b0;
          end else begin
            fastCnt_reg <= fastCnt_reg - `KBM_CNT_W'(1);
          end
        end
        KBM_FR_PULSE: begin
          if (fastCnt_reg == '0) begin
            fast_reg <= KBM_FR_DONE;
            fastCpuReset_n <= 1'b1;
          end else begin
            fastCnt_reg <= fastCnt_reg - `KBM_CNT_W'(1);
          end
        end
        KBM_FR_DONE: begin
          if (!fastCtl_reg[`KBM_FAST_RST_BIT]) begin
            fast_reg <= KBM_FR_IDLE;
          end
        end
        default: begin
          fast_reg <= KBM_FR_IDLE;
        end
      endcase
    end
  end
endmodule // kbm_mailbox

// [tb/kbm_mailbox_sva.sv]
// kbm_mailbox_sva: port-level assertions for the host mailbox block
`timescale 1ns/1ps
module kbm_mailbox_sva (
  // clocking
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  // host access
  input wire logic hostWr,
  input wire logic hostRd,
  input wire logic [7:0] hostAddr,
  input wire logic [7:0] hostWrData,
  input wire logic [7:0] hostRdData,
  input wire logic [7:0] glueConfigReg,
  // core side
  input wire logic [7:0] coreStatusRdByte,
  input wire logic coreIdleOp,
  input wire logic coreStopOp,
  input wire logic coreEnFlags,
  input wire logic corePortBit4,
  input wire logic coreAluClkEn,
  input wire logic coreTimerClkEn,
  input wire logic oscDriverEn,
  // pins
  input wire logic kbdHostIrq,
  input wire logic fastA20Gate,
  input wire logic fastCpuReset_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] lowCnt_reg;
  logic fastWr;
  logic fastRd;
  // accesses aimed at the fast gate/reset register
  assign fastWr = clkEn && hostWr && hostAddr == 8'h92;
  assign fastRd = clkEn && hostRd && hostAddr == 8'h92;
  // low phase length of fast reset; saturates so a stuck pin cannot wrap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lowCnt_reg <= 8'h00;
    end else if (fastCpuReset_n) begin
      lowCnt_reg <= 8'h00;
    end else if (lowCnt_reg != 8'hff) begin
      lowCnt_reg <= lowCnt_reg + 8'h01;
    end
  end
  a_fast_locked: assert property (fastRd && !glueConfigReg[2] |=> hostRdData == 8'h00)
    else $error("locked fast register read not zero");
  a_fast_fixed: assert property (fastRd && glueConfigReg[2] |=> (hostRdData & 8'hfc) == 8'h24)
    else $error("fast register fixed bits wrong");
  a_a20_level: assert property (fastWr && glueConfigReg[2] |=> fastA20Gate == $past(hostWrData[1]))
    else $error("a20 gate not at written level");
  a_a20_locked: assert property (fastWr && !glueConfigReg[2] |=> $stable(fastA20Gate))
    else $error("a20 gate moved by locked write");
  a_pulse_width: assert property ($rose(fastCpuReset_n) |-> lowCnt_reg >= 8'h64)
    else $error("fast reset pulse too short");
  a_cmd_flag: assert property (clkEn && hostWr && hostAddr == 8'h64 |->
    ##[1:3] (coreStatusRdByte[3] && coreStatusRdByte[1])) else $error("command write flags wrong");
  a_data_flag: assert property (clkEn && hostWr && hostAddr == 8'h60 |->
    ##[1:3] (!coreStatusRdByte[3] && coreStatusRdByte[1])) else $error("data write flags wrong");
  a_halt_clocks: assert property (clkEn && coreIdleOp |->
    ##[1:3] (!coreAluClkEn && coreTimerClkEn)) else $error("soft halt clock enables wrong");
  a_stop_osc: assert property (clkEn && coreStopOp |-> ##[1:3] !oscDriverEn)
    else $error("oscillator driver still on");
  a_kbd_forced: assert property ((coreEnFlags && !corePortBit4)[*3] |-> !kbdHostIrq)
    else $error("kbd irq not forced low");
endmodule // kbm_mailbox_sva

// [tb/kbm_host_model.sv]
// kbm_host_model: host side i/o master for the mailbox
`timescale 1ns/1ps
module kbm_host_model (
  // clocking
  input wire logic clk,
  // host strobes
  output logic hostWr,
  output logic hostRd,
  output logic [7:0] hostAddr,
  output logic [7:0] hostWrData,
  // read answer
  input wire logic [7:0] hostRdData,
  input wire logic hostRdValid
);
  initial begin
    hostWr = 1'b0;
    hostRd = 1'b0;
    hostAddr = 8'h00;
    hostWrData = 8'h00;
  end
  // one-cycle strobe; released bus shows inverted values, never the last ones
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    hostAddr = a;
    hostWrData = d;
    hostWr = 1'b1;
    @(negedge clk);
    hostWr = 1'b0;
    hostAddr = ~a;
    hostWrData = ~d;
  endtask
  // answer taken when valid shows; stays unknown if it never does
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int i;
    d = 8'hxx;
    @(negedge clk);
    hostAddr = a;
    hostRd = 1'b1;
    @(negedge clk);
    hostRd = 1'b0;
    hostAddr = ~a;
    for (i = 0; i < 4; i++) begin
      if (hostRdValid === 1'b1) begin
        d = hostRdData;
        break;
      end
      @(negedge clk);
    end
  endtask
endmodule // kbm_host_model

// [tb/kbm_mailbox_tb.sv]
// kbm_mailbox_tb: self-checking bench for the host mailbox block
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin nFail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
`define WAIT(c, n) \
  for (k = 0; k < (n) && !(c); k++) @(negedge clk); \
  if (k == (n)) tmo();
module kbm_mailbox_tb;
  int nFail = 0, checked = 0, i, k;
  logic [7:0] d;
  logic lo;
  logic clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1;
  logic [7:0] glueConfigReg = 8'h00, coreDataWrByte = 8'h00, coreStatusWrByte = 8'h00;
  logic coreDataWr = 1'b0, coreDataRd = 1'b0, coreStatusWr = 1'b0, coreIdleOp = 1'b0;
  logic coreStopOp = 1'b0, coreEnFlags = 1'b0, coreIbfIntEn = 1'b0, coreTimerOvf = 1'b0;
  logic coreTimerIntEn = 1'b0, corePortBit4 = 1'b0, corePortBit5 = 1'b0;
  logic [3:0] corePortLines = 4'hf;
  logic hostWr, hostRd, hostRdValid, coreDataReady, coreAluClkEn, coreTimerClkEn, oscDriverEn;
  logic coreTick, coreIntReq, coreIntIsTimer, kbdHostIrq, auxHostIrq, kbdClockLine;
  logic kbdDataLine, auxClockLine, auxDataLine, fastA20Gate, fastCpuReset_n;
  logic [7:0] hostAddr, hostWrData, hostRdData, coreDataRdByte, coreStatusRdByte;
  logic [1:0] coreWake;
  always #5 clk = ~clk;
  kbm_host_model host (.clk(clk), .hostWr(hostWr), .hostRd(hostRd), .hostAddr(hostAddr),
    .hostWrData(hostWrData), .hostRdData(hostRdData), .hostRdValid(hostRdValid));
  kbm_mailbox uut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .hostWr(hostWr), .hostRd(hostRd),
    .hostAddr(hostAddr), .hostWrData(hostWrData), .hostRdData(hostRdData),
    .hostRdValid(hostRdValid), .glueConfigReg(glueConfigReg), .coreDataWr(coreDataWr),
    .coreDataWrByte(coreDataWrByte), .coreDataRd(coreDataRd), .coreDataRdByte(coreDataRdByte),
    .coreDataReady(coreDataReady), .coreStatusWr(coreStatusWr),
    .coreStatusWrByte(coreStatusWrByte), .coreStatusRdByte(coreStatusRdByte),
    .coreIdleOp(coreIdleOp), .coreStopOp(coreStopOp), .coreEnFlags(coreEnFlags),
    .coreIbfIntEn(coreIbfIntEn), .coreTimerOvf(coreTimerOvf), .coreTimerIntEn(coreTimerIntEn),
    .corePortBit4(corePortBit4), .corePortBit5(corePortBit5), .corePortLines(corePortLines),
    .coreAluClkEn(coreAluClkEn), .coreTimerClkEn(coreTimerClkEn), .oscDriverEn(oscDriverEn),
    .coreTick(coreTick), .coreIntReq(coreIntReq), .coreIntIsTimer(coreIntIsTimer),
    .coreWake(coreWake), .kbdHostIrq(kbdHostIrq), .auxHostIrq(auxHostIrq),
    .kbdClockLine(kbdClockLine), .kbdDataLine(kbdDataLine), .auxClockLine(auxClockLine),
    .auxDataLine(auxDataLine), .fastA20Gate(fastA20Gate), .fastCpuReset_n(fastCpuReset_n));
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // core pulses: data write, status write, data read, idle or stop opcode
  task cwr(input logic [7:0] b);
    @(negedge clk);
    coreDataWrByte = b;
    coreDataWr = 1'b1;
    @(negedge clk);
    coreDataWr = 1'b0;
  endtask
  task cst(input logic [7:0] b);
    @(negedge clk);
    coreStatusWrByte = b;
    coreStatusWr = 1'b1;
    @(negedge clk);
    coreStatusWr = 1'b0;
  endtask
  task crd;
    @(negedge clk);
    coreDataRd = 1'b1;
    @(negedge clk);
    coreDataRd = 1'b0;
    @(negedge clk);
  endtask
  task op(input logic stop);
    @(negedge clk);
    coreStopOp = stop;
    coreIdleOp = !stop;
    @(negedge clk);
    coreStopOp = 1'b0;
    coreIdleOp = 1'b0;
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", checked, nFail);
    if (nFail == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task tmo;
    nFail++;
    final_report();
  endtask
  initial begin
    cyc(7);
    `CHK({kbdClockLine, kbdDataLine, auxClockLine, auxDataLine, fastA20Gate}, 5'h00)
    `CHK({fastCpuReset_n, coreWake}, 3'h7)
    cyc(1);
    rst_n = 1'b1;
    host.rd(8'h92, d);
    `CHK(d, 8'h00)
    host.rd(8'h64, d);
    `CHK(d, 8'h00)
    host.wr(8'h92, 8'h02);
    cyc(1);
    `CHK(fastA20Gate, 1'b0)
    glueConfigReg = 8'h04;
    host.rd(8'h92, d);
    `CHK(d, 8'h24)
    host.wr(8'h92, 8'hfa);
    host.rd(8'h92, d);
    `CHK({d, fastA20Gate}, 9'h04d)
    host.wr(8'h92, 8'h01);
    `WAIT(!fastCpuReset_n, 200)
    `CHK(k >= 49 && k <= 52 && !fastA20Gate, 1'b1)
    `WAIT(fastCpuReset_n, 300)
    `CHK(k >= 99, 1'b1)
    // a second one without clearing bit 0 first must not fire
    host.wr(8'h92, 8'h01);
    lo = 1'b0;
    repeat (150) begin
      @(negedge clk);
      lo = lo | !fastCpuReset_n;
    end
    `CHK(lo, 1'b0)
    host.wr(8'h92, 8'h00);
    host.wr(8'h92, 8'h01);
    `WAIT(!fastCpuReset_n, 100)
    `WAIT(fastCpuReset_n, 300)
    host.wr(8'h60, 8'ha5);
    cyc(2);
    `CHK(coreStatusRdByte, 8'h02)
    crd();
    `CHK(coreDataRdByte, 8'ha5)
    host.rd(8'h64, d);
    `CHK(d, 8'h00)
    host.wr(8'h64, 8'h3c);
    host.rd(8'h64, d);
    `CHK(d, 8'h0a)
    crd();
    `CHK(coreDataRdByte, 8'h3c)
    cst(8'hf4);
    host.rd(8'h64, d);
    `CHK(d, 8'hf4)
    cst(8'h00);
    coreEnFlags = 1'b1;
    corePortBit5 = 1'b1;
    cyc(3);
    `CHK({kbdHostIrq, auxHostIrq}, 2'h1)
    cwr(8'h11);
    corePortBit4 = 1'b1;
    cyc(3);
    `CHK({kbdHostIrq, coreStatusRdByte[0]}, 2'h3)
    host.rd(8'h60, d);
    cyc(2);
    `CHK({d, kbdHostIrq, coreStatusRdByte[0]}, 10'h044)
    // fill the output path while the host stalls, then drain in order
    for (i = 0; i < 12 && coreDataReady; i++) cwr(8'h20 + i[7:0]);
    `CHK(i, 9)
    for (i = 0; i < 9; i++) begin
      cyc(3);
      host.rd(8'h60, d);
      `CHK(d, 8'h20 + i[7:0])
    end
    cyc(3);
    `CHK({coreDataReady, coreStatusRdByte[0]}, 2'h2)
    coreIbfIntEn = 1'b1;
    op(1'b0);
    cyc(2);
    `CHK({coreAluClkEn, coreTimerClkEn}, 2'h1)
    host.wr(8'h60, 8'h5a);
    `WAIT(coreWake == 2'h1, 6)
    cyc(2);
    `CHK({coreAluClkEn, coreIntReq, coreIntIsTimer, auxHostIrq}, 4'hc)
    crd();
    coreIbfIntEn = 1'b0;
    op(1'b0);
    cyc(2);
    host.wr(8'h64, 8'h5b);
    `WAIT(coreWake == 2'h2, 6)
    crd();
    corePortLines = 4'h0;
    op(1'b1);
    cyc(3);
    `CHK({kbdClockLine, kbdDataLine, auxClockLine, auxDataLine}, 4'hf)
    lo = 1'b0;
    repeat (30) begin
      @(negedge clk);
      lo = lo | coreTick;
    end
    `CHK({oscDriverEn, lo}, 2'h0)
    // held long enough for the oscillator and the core reset minimum
    rst_n = 1'b0;
    cyc(200);
    `CHK({coreWake, kbdClockLine, auxDataLine}, 4'hc)
    rst_n = 1'b1;
    cyc(2);
    `CHK(oscDriverEn, 1'b1)
    host.rd(8'h92, d);
    `CHK(d, 8'h24)
    host.rd(8'h64, d);
    `CHK(d, 8'h00)
    // timer overflow is the second core interrupt source
    coreTimerIntEn = 1'b1;
    coreTimerOvf = 1'b1;
    cyc(2);
    `CHK({coreIntReq, coreIntIsTimer}, 2'h3)
    coreTimerOvf = 1'b0;
    i = 0;
    repeat (100) begin
      @(negedge clk);
      i += coreTick;
    end
    `CHK(i, 12)
    final_report();
  end
endmodule // kbm_mailbox_tb
bind kbm_mailbox kbm_mailbox_sva chk (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
  .hostWr(hostWr), .hostRd(hostRd), .hostAddr(hostAddr), .hostWrData(hostWrData),
  .hostRdData(hostRdData), .glueConfigReg(glueConfigReg), .coreStatusRdByte(coreStatusRdByte),
  .coreIdleOp(coreIdleOp), .coreStopOp(coreStopOp), .coreEnFlags(coreEnFlags),
  .corePortBit4(corePortBit4), .coreAluClkEn(coreAluClkEn), .coreTimerClkEn(coreTimerClkEn),
  .oscDriverEn(oscDriverEn), .kbdHostIrq(kbdHostIrq), .fastA20Gate(fastA20Gate),
  .fastCpuReset_n(fastCpuReset_n));
